// ---- rtl/pirs_map.svh ----
/*
  Offsets, field positions, reset values and timing counts for the
  phase interleave and ramp synchronisation block.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef PIRS_MAP_SVH
`define PIRS_MAP_SVH

`define PIRS_CLK_HZ           20000000
`define PIRS_OFF_CTRL         32'h0000_0000
`define PIRS_OFF_GROUP        32'h0000_0004
`define PIRS_OFF_ACTIVE       32'h0000_0008
`define PIRS_OFF_DELAY_ON     32'h0000_000c
`define PIRS_OFF_DELAY_OFF    32'h0000_0010
`define PIRS_OFF_MINPW        32'h0000_0014
`define PIRS_OFF_STATUS       32'h0000_0018
`define PIRS_CTRL_ENABLE      0
`define PIRS_CTRL_SHARE       1
`define PIRS_CTRL_DUAL        2
`define PIRS_CTRL_MINPW_EN    3
`define PIRS_CTRL_SYNC_DRIVE  4
`define PIRS_CTRL_SYNC_OD     5
`define PIRS_GRP_COUNT_LSB    0
`define PIRS_GRP_POS_LSB      4
`define PIRS_GRP_ILV_LSB      8
`define PIRS_RST_CTRL         32'h0000_0000
`define PIRS_RST_GROUP        32'h0000_0000
`define PIRS_RST_ACTIVE       8'hff
`define PIRS_RST_DELAY        32'h0000_0000
`define PIRS_RST_MINPW        32'h0000_0000
`define PIRS_FW_CYCLE_NS      100000
`define PIRS_FW_CYCLES        (((`PIRS_FW_CYCLE_NS) * ((`PIRS_CLK_HZ) / 1000000) + 999) / 1000)
`define PIRS_MINPW_DIV_SHIFT  7
`define PIRS_STEPS            16
`define PIRS_MAX_PHASES       8

`endif

// ---- rtl/pirs_pkg.sv ----
/*
  Types for the phase interleave and ramp synchronisation block.
  Assumes nothing of its surroundings.
*/
package pirs_pkg;
  typedef enum logic [2:0] {
    PIRS_IDLE,
    PIRS_FROZEN,
    PIRS_RAMP_UP,
    PIRS_RUN,
    PIRS_OFF_WAIT,
    PIRS_RAMP_DOWN
  } pirs_state_t;
  typedef logic [3:0] pirs_code_t;
endpackage

// ---- rtl/pirs_offset_calc.sv ----
/*
  Quantised phase offset from group size, active set, position and
  manual interleave. Purely combinational.
  Assumes stable configuration inputs.
*/
`timescale 1ns/1ps
`include "pirs_map.svh"

module pirs_offset_calc (
  input  wire logic [3:0]          count,
  input  wire logic [2:0]          position,
  input  wire logic [7:0]          active,
  input  wire logic                share_en,
  input  wire pirs_pkg::pirs_code_t interleave,
  output pirs_pkg::pirs_code_t     offset,
  output logic [2:0]               ref_pos,
  output logic [3:0]               n_active,
  output logic                     is_ref
);

  function automatic logic [3:0] pirs_popcnt(input logic [7:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 8; i++) begin
      c = c + {3'h0, v[i]};
    end
    return c;
  endfunction

  logic [7:0] in_group;
  logic [3:0] rank;
  logic [7:0] num;
  logic [7:0] quo;
  logic [3:0] base;

  always_comb begin
    in_group = 8'h00;
    for (int i = 0; i < 8; i++) begin
      in_group[i] = active[i] && (4'(i) < count);
    end
  end

  // Reference is the lowest active position
  always_comb begin
    ref_pos = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (in_group[i]) begin
        ref_pos = 3'(i);
      end
    end
  end

  always_comb begin
    n_active = pirs_popcnt(in_group);
    rank = pirs_popcnt(in_group & ((8'h01 << position) - 8'h01));
    is_ref = share_en && in_group[position] && (ref_pos == position);
  end

  // round(rank*16/n), halves round up
  always_comb begin
    num  = 8'({rank, 5'h00}) + 8'(n_active);
    quo  = (n_active == 4'h0) ? 8'h00 : num / {4'h0, n_active} / 8'h02;
    base = (share_en && n_active >= 4'h2) ? quo[3:0] : 4'h0;
    offset = base + interleave;
  end

endmodule

// ---- rtl/pirs_sync_gen.sv ----
/*
  Phase-shifted switching start derived from the shared sync clock.
  Measures the sync period, places the start pulse at offset/16 of it,
  optionally drives the sync pin from an internal divider.
  Assumes sync input synchronous to hclk.
*/
`timescale 1ns/1ps
`include "pirs_map.svh"

module pirs_sync_gen (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 sync_in,
  input  wire logic                 drive_en,
  input  wire logic                 open_drain,
  input  wire logic [15:0]          half_period,
  input  wire pirs_pkg::pirs_code_t offset,
  output logic                      sync_out,
  output logic                      sync_oe,
  output logic                      pwm_start,
  output logic [15:0]               period
);

  logic [15:0] div_reg;
  logic        clk_reg;
  logic        prev_reg;
  logic [15:0] cnt_reg;
  logic [15:0] period_reg;
  logic [19:0] target;
  logic        pin_level;
  logic        rise;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 16'h0000;
      clk_reg <= 1'b0;
    end else if (div_reg >= half_period) begin
      div_reg <= 16'h0000;
      clk_reg <= ~clk_reg;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // Push-pull drives both levels, open-drain only pulls low
  always_comb begin
    sync_out = open_drain ? 1'b0 : clk_reg;
    sync_oe  = drive_en && (open_drain ? !clk_reg : 1'b1);
    pin_level = drive_en ? clk_reg : sync_in;
    rise = pin_level && !prev_reg;
    target = ({4'h0, period_reg} * {16'h0000, offset}) >> 4;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // Sync line idles high; no false edge after reset
      prev_reg   <= 1'b1;
      cnt_reg    <= 16'h0000;
      period_reg <= 16'h0000;
      pwm_start  <= 1'b0;
    end else begin
      prev_reg  <= pin_level;
      pwm_start <= (cnt_reg == target[15:0]) && (period_reg != 16'h0000);
      if (rise) begin
        cnt_reg    <= 16'h0000;
        period_reg <= cnt_reg + 16'h0001;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  assign period = period_reg;

endmodule

// ---- rtl/pirs_core.sv ----
/*
  Per-phase interleave and ramp synchronisation controller with an
  AHB-Lite register slave.
  Assumes one clock, a single AHB-Lite master, peers on a wired ramp
  flag line of the event bus.
*/
`timescale 1ns/1ps
`include "pirs_map.svh"

module pirs_core (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic             sync_oe,
  input  wire logic        ramp_flag_in,
  output logic             ramp_flag_out,
  output logic             ramp_flag_oe,
  output logic             pwm_start,
  output logic             pwm_enable,
  output logic             regulate,
  output logic             ramp_up,
  output logic             ramp_down,
  output logic             ramp_dual,
  output logic             state_frozen,
  output logic [15:0]      min_pulse
);

  pirs_pkg::pirs_state_t state_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] group_reg;
  logic [7:0]  active_reg;
  logic [31:0] don_reg;
  logic [31:0] doff_reg;
  logic [31:0] minpw_reg;
  logic [31:0] dly_reg;
  logic        wr_pend_reg;
  logic [31:0] wr_addr_reg;
  logic        enable_prev_reg;

  pirs_pkg::pirs_code_t offset;
  logic [2:0]  ref_pos;
  logic [3:0]  n_active;
  logic        is_ref;
  logic [15:0] period;
  logic        enable;
  logic        share_en;
  logic        dual;
  logic        addr_phase;
  logic [31:0] status;

  function automatic logic [31:0] pirs_decode_read(input logic [31:0] a, input logic [31:0] st,
                                                   input logic [31:0] c, input logic [31:0] g,
                                                   input logic [7:0] act, input logic [31:0] on,
                                                   input logic [31:0] off, input logic [31:0] mp);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a[7:0])
      8'(`PIRS_OFF_CTRL):      r = c;
      8'(`PIRS_OFF_GROUP):     r = g;
      8'(`PIRS_OFF_ACTIVE):    r = {24'h00_0000, act};
      8'(`PIRS_OFF_DELAY_ON):  r = on;
      8'(`PIRS_OFF_DELAY_OFF): r = off;
      8'(`PIRS_OFF_MINPW):     r = mp;
      8'(`PIRS_OFF_STATUS):    r = st;
      default:                 r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  assign enable   = ctrl_reg[`PIRS_CTRL_ENABLE];
  assign share_en = ctrl_reg[`PIRS_CTRL_SHARE];
  assign dual     = ctrl_reg[`PIRS_CTRL_DUAL];

  pirs_offset_calc u_offset (
    .count      (group_reg[`PIRS_GRP_COUNT_LSB +: 4]),
    .position   (group_reg[`PIRS_GRP_POS_LSB +: 3]),
    .active     (active_reg),
    .share_en   (share_en),
    .interleave (group_reg[`PIRS_GRP_ILV_LSB +: 4]),
    .offset     (offset),
    .ref_pos    (ref_pos),
    .n_active   (n_active),
    .is_ref     (is_ref)
  );

  pirs_sync_gen u_sync (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .sync_in     (sync_in),
    .drive_en    (ctrl_reg[`PIRS_CTRL_SYNC_DRIVE]),
    .open_drain  (ctrl_reg[`PIRS_CTRL_SYNC_OD]),
    .half_period (group_reg[31:16]),
    .offset      (offset),
    .sync_out    (sync_out),
    .sync_oe     (sync_oe),
    .pwm_start   (pwm_start),
    .period      (period)
  );

  // Bus slave: zero wait states, write data stored in the data phase
  assign addr_phase = hsel && hready && htrans[1];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_addr_reg <= haddr;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= pirs_decode_read(haddr, status, ctrl_reg, group_reg, active_reg,
                                 don_reg, doff_reg, minpw_reg);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg   <= `PIRS_RST_CTRL;
      group_reg  <= `PIRS_RST_GROUP;
      active_reg <= `PIRS_RST_ACTIVE;
      don_reg    <= `PIRS_RST_DELAY;
      doff_reg   <= `PIRS_RST_DELAY;
      minpw_reg  <= `PIRS_RST_MINPW;
    end else if (wr_pend_reg) begin
      unique case (wr_addr_reg[7:0])
        8'(`PIRS_OFF_CTRL):      ctrl_reg <= hwdata;
        8'(`PIRS_OFF_GROUP):     group_reg <= hwdata;
        8'(`PIRS_OFF_ACTIVE):    active_reg <= hwdata[7:0];
        8'(`PIRS_OFF_DELAY_ON):  don_reg <= hwdata;
        8'(`PIRS_OFF_DELAY_OFF): doff_reg <= hwdata;
        8'(`PIRS_OFF_MINPW):     minpw_reg <= hwdata;
        default: ;
      endcase
    end
  end

  assign status = {8'h00, 4'h0, offset, 1'b0, ref_pos, n_active,
                   1'b0, is_ref, ramp_flag_in, 2'b00, 3'(state_reg)};

  // Sequencer: enable freezes, reference broadcasts, members ramp on the flag; unshared phases ramp after their own delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg       <= pirs_pkg::PIRS_IDLE;
      dly_reg         <= 32'h0000_0000;
      enable_prev_reg <= 1'b0;
      ramp_flag_out   <= 1'b0;
    end else begin
      enable_prev_reg <= enable;
      ramp_flag_out   <= 1'b0;
      unique case (state_reg)
        pirs_pkg::PIRS_IDLE: begin
          if (enable && !enable_prev_reg) begin
            state_reg <= pirs_pkg::PIRS_FROZEN;
            dly_reg   <= don_reg + (is_ref ? 32'(`PIRS_FW_CYCLES) : 32'h0000_0000);
          end
        end
        pirs_pkg::PIRS_FROZEN: begin
          if (!enable) begin
            state_reg <= pirs_pkg::PIRS_IDLE;
          end else if (!share_en || is_ref) begin
            if (dly_reg == 32'h0000_0000) begin
              state_reg     <= pirs_pkg::PIRS_RAMP_UP;
              ramp_flag_out <= share_en;
            end else begin
              dly_reg <= dly_reg - 32'h0000_0001;
            end
          end else if (ramp_flag_in) begin
            state_reg <= pirs_pkg::PIRS_RAMP_UP;
          end
        end
        pirs_pkg::PIRS_RAMP_UP: begin
          state_reg <= enable ? pirs_pkg::PIRS_RUN : pirs_pkg::PIRS_IDLE;
        end
        pirs_pkg::PIRS_RUN: begin
          if (!enable) begin
            state_reg <= pirs_pkg::PIRS_OFF_WAIT;
            dly_reg   <= doff_reg + (is_ref ? 32'(`PIRS_FW_CYCLES) : 32'h0000_0000);
          end
        end
        pirs_pkg::PIRS_OFF_WAIT: begin
          if (!share_en || is_ref) begin
            if (dly_reg == 32'h0000_0000) begin
              state_reg     <= pirs_pkg::PIRS_RAMP_DOWN;
              ramp_flag_out <= share_en;
            end else begin
              dly_reg <= dly_reg - 32'h0000_0001;
            end
          end else if (ramp_flag_in) begin
            state_reg <= pirs_pkg::PIRS_RAMP_DOWN;
          end
        end
        pirs_pkg::PIRS_RAMP_DOWN: begin
          state_reg <= pirs_pkg::PIRS_IDLE;
        end
      endcase
    end
  end

  // Flag line is open-drain style: driven only while asserted
  assign ramp_flag_oe = ramp_flag_out;

  always_comb begin
    state_frozen = (state_reg == pirs_pkg::PIRS_FROZEN);
    ramp_up      = (state_reg == pirs_pkg::PIRS_RAMP_UP);
    ramp_down    = (state_reg == pirs_pkg::PIRS_RAMP_DOWN);
    pwm_enable   = (state_reg == pirs_pkg::PIRS_RAMP_UP) || (state_reg == pirs_pkg::PIRS_RUN) ||
                   (state_reg == pirs_pkg::PIRS_OFF_WAIT);
    regulate     = pwm_enable || (state_frozen && !dual);
    ramp_dual    = dual && ramp_up;
  end

  // Minimum pulse is the sync period scaled by 1/128 unless overridden
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      min_pulse <= 16'h0000;
    end else if (!ctrl_reg[`PIRS_CTRL_MINPW_EN]) begin
      min_pulse <= 16'h0000;
    end else if (minpw_reg[15:0] != 16'h0000) begin
      min_pulse <= minpw_reg[15:0];
    end else begin
      min_pulse <= period >> `PIRS_MINPW_DIV_SHIFT;
    end
  end

endmodule

// ---- testbench/pirs_core_chk.sv ----
/*
  Concurrent checks on the ports of the phase interleave and ramp
  synchronisation core. Assumes one clock and the bind at the foot.
*/
`timescale 1ns/1ps

module pirs_core_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic ramp_flag_in,
  input wire logic ramp_flag_out,
  input wire logic ramp_flag_oe,
  input wire logic ramp_up,
  input wire logic ramp_down,
  input wire logic pwm_start,
  input wire logic pwm_enable,
  input wire logic state_frozen
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_bus_zero_wait: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
  a_flag_oe_tied: assert property (ramp_flag_oe == ramp_flag_out)
    else $error("ramp flag enable differs from flag");
  a_flag_from_wait: assert property (ramp_flag_out |-> $past(state_frozen) || $past(pwm_enable))
    else $error("ramp flag raised outside a wait state");
  a_flag_one_cycle: assert property (ramp_flag_out |=> !ramp_flag_out)
    else $error("ramp flag longer than one cycle");
  a_flag_then_ramp: assert property (ramp_flag_out |-> ##[0:2] (ramp_up || ramp_down))
    else $error("reference ramp missing after flag");
  a_member_follows: assert property ($rose(ramp_flag_in) && state_frozen |-> ##[0:3] ramp_up)
    else $error("frozen member did not start ramp");
  a_frozen_no_pwm: assert property (state_frozen |-> !pwm_enable)
    else $error("switching while frozen");
  a_ramp_up_once: assert property (ramp_up |=> !ramp_up && !state_frozen)
    else $error("ramp up not a single step");
  a_ramp_down_once: assert property (ramp_down |=> !ramp_down)
    else $error("ramp down not a single step");
  a_pwm_start_pulse: assert property (pwm_start |=> !pwm_start)
    else $error("switching start longer than one cycle");
endmodule

bind pirs_core pirs_core_chk u_chk (
  .hclk          (hclk),
  .hresetn       (hresetn),
  .hreadyout     (hreadyout),
  .hresp         (hresp),
  .ramp_flag_in  (ramp_flag_in),
  .ramp_flag_out (ramp_flag_out),
  .ramp_flag_oe  (ramp_flag_oe),
  .ramp_up       (ramp_up),
  .ramp_down     (ramp_down),
  .pwm_start     (pwm_start),
  .pwm_enable    (pwm_enable),
  .state_frozen  (state_frozen)
);

// ---- testbench/pirs_peer.sv ----
/*
  Peer phase controller: sync clock source and reference ramp flag.
  Assumes it shares hclk with the core; sync stands still when idle.
*/
`timescale 1ns/1ps

module pirs_peer #(
  parameter int HALF = 128
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        run,
  input  wire logic        fire,
  input  wire logic [15:0] dly,
  output logic             sync,
  output logic             flag
);
  logic [15:0] t;
  logic [15:0] w;
  logic        arm;

  // Sync source while run is high, same period for every member
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn || !run) begin
      sync <= 1'b0;
      t    <= 16'h0;
    end else if (t == 16'(HALF - 1)) begin
      t    <= 16'h0;
      sync <= ~sync;
    end else begin
      t <= t + 16'h1;
    end
  end

  // Reference: longer delay, then one flag pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      arm  <= 1'b0;
      w    <= 16'h0;
      flag <= 1'b0;
    end else begin
      flag <= 1'b0;
      if (fire && !arm) begin
        arm <= 1'b1;
        w   <= dly;
      end else if (arm && w == 16'h0) begin
        arm  <= 1'b0;
        flag <= 1'b1;
      end else if (arm) begin
        w <= w - 16'h1;
      end
    end
  end
endmodule

// ---- testbench/test_pirs_core.sv ----
/*
  Self-checking bench for the core: registers over AHB-Lite, offsets,
  ramp synchronisation and sync drive. Assumes a peer model on the far side.
*/
`timescale 1ns/1ps
`include "pirs_map.svh"

module test_pirs_core;
  logic        hclk, hresetn, hsel, hwrite, run, fire, prev;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [15:0] dly, min_pulse;
  logic        hreadyout, hresp, sync_in, sync_out, sync_oe, p_sync, p_flag;
  logic        ramp_flag_in, ramp_flag_out, ramp_flag_oe, pwm_start, pwm_enable;
  logic        regulate, ramp_up, ramp_down, ramp_dual, state_frozen;
  int          mismatches, samples_checked, n, i, k, e;
  localparam logic [31:0] OT [9] = '{32'hff02_0003, 32'hff52_0013, 32'hffb2_0023,
    32'hff42_0402, 32'hffc2_0412, 32'hffe2_0078, 32'hff30_0323, 32'hff02_0001, 32'h0682_0023};

  // Idle peer releases the sync line to its pull-up
  assign sync_in      = sync_oe ? sync_out : (run ? p_sync : 1'b1);
  assign ramp_flag_in = ramp_flag_oe | p_flag;

  pirs_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sync_in(sync_in), .sync_out(sync_out),
    .sync_oe(sync_oe), .ramp_flag_in(ramp_flag_in), .ramp_flag_out(ramp_flag_out),
    .ramp_flag_oe(ramp_flag_oe), .pwm_start(pwm_start), .pwm_enable(pwm_enable),
    .regulate(regulate), .ramp_up(ramp_up), .ramp_down(ramp_down), .ramp_dual(ramp_dual),
    .state_frozen(state_frozen), .min_pulse(min_pulse));

  pirs_peer #(.HALF(128)) peer (.hclk(hclk), .hresetn(hresetn), .run(run), .fire(fire),
    .dly(dly), .sync(p_sync), .flag(p_flag));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task results;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task t_reset;
    for (i = 0; i < 6; i++) begin
      bus(1'b0, 32'(i * 4), 32'h0);
      chk("reset value", (i == 2) ? 32'hff : 32'h0, q);
    end
    bus(1'b1, 32'h40, 32'hffff_ffff);
    bus(1'b0, 32'h40, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask

  task t_offsets;
    for (i = 0; i < 9; i++) begin
      bus(1'b1, `PIRS_OFF_CTRL, {28'h0, OT[i][19:16]});
      bus(1'b1, `PIRS_OFF_GROUP, {20'h0, OT[i][11:0]});
      bus(1'b1, `PIRS_OFF_ACTIVE, {24'h0, OT[i][31:24]});
      bus(1'b0, `PIRS_OFF_STATUS, 32'h0);
      chk("offset", {28'h0, OT[i][23:20]}, {28'h0, q[19:16]});
    end
    chk("ref_pos", 32'h1, {29'h0, q[14:12]});
    chk("n_active", 32'h2, {28'h0, q[11:8]});
    bus(1'b1, `PIRS_OFF_ACTIVE, 32'hff);
  endtask

  task t_ref_ramp;
    bus(1'b1, `PIRS_OFF_GROUP, 32'h003);
    bus(1'b1, `PIRS_OFF_DELAY_ON, 32'h5);
    bus(1'b1, `PIRS_OFF_DELAY_OFF, 32'h3);
    bus(1'b1, `PIRS_OFF_CTRL, 32'hf);
    for (n = 0; n < 3000 && ramp_flag_out !== 1'b1; n++) @(negedge hclk);
    chk("on wait", 32'h1, {31'h0, n >= 2003 && n <= 2010});
    bus(1'b0, `PIRS_OFF_STATUS, 32'h0);
    chk("run state", 32'h3, {29'h0, q[2:0]});
    chk("is_ref", 32'h1, {31'h0, q[6]});
    bus(1'b1, `PIRS_OFF_CTRL, 32'he);
    for (n = 0; n < 3000 && ramp_flag_out !== 1'b1; n++) @(negedge hclk);
    chk("off wait", 32'h1, {31'h0, n >= 2001 && n <= 2008});
    bus(1'b0, `PIRS_OFF_STATUS, 32'h0);
    chk("idle state", 32'h0, {29'h0, q[2:0]});
  endtask

  task t_member;
    bus(1'b1, `PIRS_OFF_GROUP, 32'h013);
    bus(1'b1, `PIRS_OFF_CTRL, 32'hf);
    repeat (50) @(negedge hclk);
    chk("frozen", 32'h1, {31'h0, state_frozen});
    chk("member flag", 32'h0, {31'h0, ramp_flag_out});
    chk("frozen regulate", 32'h0, {31'h0, regulate});
    chk("frozen pwm", 32'h0, {31'h0, pwm_enable});
    @(posedge hclk);
    fire <= 1'b1;
    dly  <= 16'd20;
    @(posedge hclk);
    fire <= 1'b0;
    for (n = 0; n < 40 && ramp_up !== 1'b1; n++) @(negedge hclk);
    chk("member start", 32'h1, {31'h0, n >= 19 && n <= 26});
    chk("dual ramp", 32'h1, {31'h0, ramp_dual});
    bus(1'b1, `PIRS_OFF_CTRL, 32'he);
    repeat (20) @(negedge hclk);
    bus(1'b0, `PIRS_OFF_STATUS, 32'h0);
    chk("off wait state", 32'h4, {29'h0, q[2:0]});
    dly  <= 16'd0;
    fire <= 1'b1;
    @(posedge hclk);
    fire <= 1'b0;
    for (n = 0; n < 10 && ramp_down !== 1'b1; n++) @(negedge hclk);
    chk("member stop", 32'h1, {31'h0, n < 10});
  endtask

  task t_pwm;
    bus(1'b1, `PIRS_OFF_CTRL, 32'ha);
    bus(1'b1, `PIRS_OFF_GROUP, 32'h402);
    bus(1'b1, `PIRS_OFF_MINPW, 32'h0);
    run <= 1'b1;
    repeat (800) @(negedge hclk);
    @(posedge sync_in);
    for (n = 0; n < 300 && pwm_start !== 1'b1; n++) @(negedge hclk);
    chk("pwm delay", 32'h1, {31'h0, n >= 62 && n <= 70});
    chk("min pulse", 32'h2, {16'h0, min_pulse});
    bus(1'b1, `PIRS_OFF_MINPW, 32'h7);
    repeat (3) @(negedge hclk);
    chk("min pulse set", 32'h7, {16'h0, min_pulse});
    @(posedge hclk);
    run <= 1'b0;
  endtask

  task t_drive(input logic [31:0] c);
    bus(1'b1, `PIRS_OFF_GROUP, 32'h0008_0000);
    bus(1'b1, `PIRS_OFF_CTRL, c);
    k    = 0;
    e    = 0;
    @(negedge hclk);
    prev = sync_in;
    for (i = 0; i < 64; i++) begin
      @(negedge hclk);
      if (sync_in && !prev)
        k++;
      if (c[5] ? (sync_oe === 1'b1 && sync_out !== 1'b0) : (sync_oe !== 1'b1))
        e++;
      prev = sync_in;
    end
    chk("sync edges", 32'h1, {31'h0, k >= 3 && k <= 5});
    chk("sync drive", 32'h0, 32'(e));
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    results;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    run = 1'b0;
    fire = 1'b0;
    dly = 16'h0;
    mismatches = 0;
    samples_checked = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_offsets;
    t_ref_ramp;
    t_member;
    t_pwm;
    t_drive(32'h10);
    t_drive(32'h30);
    results;
  end
endmodule
